// file: hw/event_selection_control_reg_match.sv
`timescale 1ns/100ps
`include "replay_split_map.svh"
module sel_match #(
  parameter bit         ORDER_GROUP = 1'b0,
  parameter bit         IS_B        = 1'b0,
  parameter logic [6:0] ORDER_CODE  = 7'h03
) (
  sel_match_if.decoder m
);
  logic [6:0]              code;
  logic [`RS_MASK_W-1:0]   mask;
  replay_split_pkg::event_class_e cls;
  logic                    replay_ok;

  assign code = m.sel[`RS_CODE_MSB:`RS_CODE_LSB];
  assign mask = m.sel[`RS_MASK_MSB:`RS_MASK_LSB];
  assign cls  = replay_split_pkg::decode_class(code);
  // at-retirement replays are only delivered through the second register
  assign replay_ok = IS_B || !m.at_retire;

  always_comb begin
    m.hit = 1'b0;
    if (ORDER_GROUP) begin
      m.hit = (code == ORDER_CODE) && |(m.order_cause & mask);
    end else begin
      unique case (cls)
        replay_split_pkg::CLS_SPLIT_DONE: begin
          m.hit = (mask[`RS_LOAD_SPLIT_COMPLETED_BIT] && m.split_load_cause_bit && !m.split_load_cause_bit_ucwc) ||
                  (mask[`RS_STORE_SPLIT_COMPLETED_BIT] && m.split_store_cause_bit);
        end
        replay_split_pkg::CLS_LOAD_REPLAY: begin
          m.hit = replay_ok && |(m.ld_cause & mask);
        end
        replay_split_pkg::CLS_STORE_REPLAY: begin
          m.hit = replay_ok && |(m.st_cause & mask);
        end
        replay_split_pkg::CLS_NONE: begin
          m.hit = 1'b0;
        end
      endcase
    end
  end
endmodule : sel_match

// file: hw/replay_split_event_select.sv
// Function
// - The split-completion event counts split loads and split stores chosen by mask bits, never uncacheable split loads.
// - Code 08H with mask bit 0 counts completed split loads, not uncacheable or write-combining ones.
// - Code 08H with mask bit 1 counts every completed split store.
// - Code 04H with mask bit 1 counts load-port replays caused by split loads.
// - Code 05H with mask bit 1 counts store-port replays caused by split stores.
// - Replay events count only when the replay cause matches a set bit of the 16-bit mask.
// - The ordering-buffer load-replay event fires when the ordering buffer replays a load, gated by mask.
// - Ordering-buffer events reach counters 0 and 1 via the first register and 2 and 3 via the second.
// - Split and port-replay events reach counters 8 and 9 via the first register and 10 and 11 via the second.
// - The event code is bits 31 down to 25 of the selection register.
`timescale 1ns/100ps
`include "replay_split_map.svh"
module replay_split_event_select #(
  parameter int         NUM_COUNTERS     = 12,
  // arbitrary default: the ordering-buffer code is not fixed here
  parameter logic [6:0] ORDER_EVENT_CODE = 7'h03
) (
  // clock and reset
  input  wire logic                          i_clk,
  input  wire logic                          i_rstn,
  // selection registers
  input  wire logic [31:0]                   i_split_access_select_reg_a,
  input  wire logic [31:0]                   i_split_access_select_reg_b,
  input  wire logic [31:0]                   i_ordering_buffer_select_reg_a,
  input  wire logic [31:0]                   i_ordering_buffer_select_reg_b,
  // counter configuration
  input  wire logic [NUM_COUNTERS-1:0][31:0] i_counter_config_control_reg,
  input  wire logic [NUM_COUNTERS-1:0]       i_counter_enable,
  // core conditions
  input  wire logic                          i_split_load_done,
  input  wire logic                          i_split_load_ucwc,
  input  wire logic                          i_split_store_done,
  input  wire logic [15:0]                   i_load_replay_cause,
  input  wire logic [15:0]                   i_store_replay_cause,
  input  wire logic [15:0]                   i_ordering_buffer_load_replay_cause,
  input  wire logic                          i_replay_at_retire,
  // results
  output logic      [NUM_COUNTERS-1:0]       o_count_inc,
  output logic      [3:0]                    o_event_hit
);
  localparam replay_split_pkg::sel_idx_t SPLIT_A = 2'h0;
  localparam replay_split_pkg::sel_idx_t SPLIT_B = 2'h1;
  localparam replay_split_pkg::sel_idx_t ORDER_A = 2'h2;
  localparam replay_split_pkg::sel_idx_t ORDER_B = 2'h3;

  if (NUM_COUNTERS != `RS_NUM_COUNTERS) begin : g_bad_count
    $error("NUM_COUNTERS must be 12");
  end

  replay_split_pkg::sel_state_s state_reg;
  replay_split_pkg::sel_state_s state_next;
  logic [3:0]  hit;
  logic [31:0] sel_word [4];

  assign sel_word[SPLIT_A] = i_split_access_select_reg_a;
  assign sel_word[SPLIT_B] = i_split_access_select_reg_b;
  assign sel_word[ORDER_A] = i_ordering_buffer_select_reg_a;
  assign sel_word[ORDER_B] = i_ordering_buffer_select_reg_b;

  // one decoder per selection register
  for (genvar g = 0; g < 4; g++) begin : g_dec
    sel_match_if mif ();
    assign mif.sel           = sel_word[g];
    assign mif.split_load_cause_bit      = i_split_load_done;
    assign mif.split_load_cause_bit_ucwc = i_split_load_ucwc;
    assign mif.split_store_cause_bit      = i_split_store_done;
    assign mif.ld_cause      = i_load_replay_cause;
    assign mif.st_cause      = i_store_replay_cause;
    assign mif.order_cause   = i_ordering_buffer_load_replay_cause;
    assign mif.at_retire     = i_replay_at_retire;
    assign hit[g]            = mif.hit;
    sel_match #(
      .ORDER_GROUP (g >= 2),
      .IS_B        (g % 2 == 1),
      .ORDER_CODE  (ORDER_EVENT_CODE)
    ) u_match (
      .m (mif.decoder)
    );
  end

  // which selection register feeds counter k, bit 2 = routed at all
  function automatic logic [2:0] ctr_source(input int k);
    logic [2:0] s;
    s = 3'h0;
    if (k == `RS_ORDER_A_CTR0 || k == `RS_ORDER_A_CTR1) s = {1'b1, ORDER_A};
    else if (k == `RS_ORDER_B_CTR0 || k == `RS_ORDER_B_CTR1) s = {1'b1, ORDER_B};
    else if (k == `RS_SPLIT_A_CTR0 || k == `RS_SPLIT_A_CTR1) s = {1'b1, SPLIT_A};
    else if (k == `RS_SPLIT_B_CTR0 || k == `RS_SPLIT_B_CTR1) s = {1'b1, SPLIT_B};
    return s;
  endfunction : ctr_source

  always_comb begin
    logic [2:0] src;
    logic [2:0] need;
    src        = 3'h0;
    need       = 3'h0;
    state_next = state_reg;
    state_next.hit = hit;
    for (int k = 0; k < NUM_COUNTERS; k++) begin
      src  = ctr_source(k);
      need = (src[1:0] >= ORDER_A) ? `RS_SEL_ORDER : `RS_SEL_SPLIT;
      state_next.inc[k] = src[2] && i_counter_enable[k] && hit[src[1:0]] &&
                          (i_counter_config_control_reg[k][`RS_SEL_MSB:`RS_SEL_LSB] == need);
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_count_inc = state_reg.inc;
  assign o_event_hit = state_reg.hit;

  // checks: conditions in one cycle, registered answer in the next, except p_unrouted_idle and p_order_idle, which look at registered outputs only
  property p_unrouted_idle;
    @(posedge i_clk) disable iff (!i_rstn)
      o_count_inc[7:4] == 4'h0;
  endproperty
  a_unrouted_idle: assert property (p_unrouted_idle) else $error("counter 4-7 fired");

  property p_split_load;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_counter_enable[8] && i_counter_config_control_reg[8][15:13] == 3'h2 &&
       i_split_access_select_reg_a[31:25] == 7'h08 && i_split_access_select_reg_a[9] &&
       i_split_load_done && !i_split_load_ucwc) |=> o_count_inc[8];
  endproperty
  a_split_load: assert property (p_split_load) else $error("split load not counted");

  property p_split_load_ucwc;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_split_access_select_reg_a[31:25] == 7'h08 && i_split_access_select_reg_a[24:9] == 16'h0001 &&
       i_split_load_ucwc) |=> !o_count_inc[8] && !o_count_inc[9];
  endproperty
  a_split_load_ucwc: assert property (p_split_load_ucwc) else $error("uncacheable split counted");

  property p_split_store;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_counter_enable[11] && i_counter_config_control_reg[11][15:13] == 3'h2 &&
       i_split_access_select_reg_b[31:25] == 7'h08 && i_split_access_select_reg_b[10] &&
       i_split_store_done) |=> o_count_inc[11] && o_event_hit[1];
  endproperty
  a_split_store: assert property (p_split_store) else $error("split store not counted");

  property p_load_replay;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_counter_enable[10] && i_counter_config_control_reg[10][15:13] == 3'h2 &&
       i_split_access_select_reg_b[31:25] == 7'h04 && i_split_access_select_reg_b[10] &&
       i_load_replay_cause[1]) |=> o_count_inc[10];
  endproperty
  a_load_replay: assert property (p_load_replay) else $error("load replay not counted");

  property p_store_replay;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_counter_enable[9] && i_counter_config_control_reg[9][15:13] == 3'h2 && !i_replay_at_retire &&
       i_split_access_select_reg_a[31:25] == 7'h05 && i_split_access_select_reg_a[10] &&
       i_store_replay_cause[1]) |=> o_count_inc[9];
  endproperty
  a_store_replay: assert property (p_store_replay) else $error("store replay not counted");

  property p_mask_gate;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_split_access_select_reg_b[31:25] == 7'h04 &&
       (i_load_replay_cause & i_split_access_select_reg_b[24:9]) == 16'h0000) |=> !o_event_hit[1];
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("unmasked replay counted");

  // counter 2 counts via the second ordering register and counter 0 stays idle while the first cannot match
  property p_order_replay;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_counter_enable[2] && i_counter_config_control_reg[2][15:13] == 3'h2 &&
       i_ordering_buffer_select_reg_a[31:25] != ORDER_EVENT_CODE &&
       i_ordering_buffer_select_reg_b[31:25] == ORDER_EVENT_CODE &&
       |(i_ordering_buffer_load_replay_cause & i_ordering_buffer_select_reg_b[24:9]))
      |=> o_count_inc[2] && !o_count_inc[0];
  endproperty
  a_order_replay: assert property (p_order_replay) else $error("ordering replay misrouted");

  property p_selector;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_counter_config_control_reg[8][15:13] != 3'h2) |=> !o_count_inc[8];
  endproperty
  a_selector: assert property (p_selector) else $error("wrong selector counted");

  property p_code_field;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_split_access_select_reg_a[31:25] != 7'h08 && i_split_access_select_reg_a[31:25] != 7'h04 &&
       i_split_access_select_reg_a[31:25] != 7'h05) |=> !o_event_hit[0] [*1] ##0 !o_count_inc[8];
  endproperty
  a_code_field: assert property (p_code_field) else $error("unknown code counted");

  property p_order_idle;
    @(posedge i_clk) disable iff (!i_rstn)
      (!o_event_hit[2] && !o_event_hit[3]) |-> o_count_inc[3:0] == 4'h0;
  endproperty
  a_order_idle: assert property (p_order_idle) else $error("counter 0-3 without event");

  property p_order_a_route;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_counter_enable[1] && i_counter_config_control_reg[1][15:13] == 3'h2 &&
       i_ordering_buffer_select_reg_a[31:25] == ORDER_EVENT_CODE &&
       |(i_ordering_buffer_load_replay_cause & i_ordering_buffer_select_reg_a[24:9]))
      |=> o_count_inc[1] && o_event_hit[2];
  endproperty
  a_order_a_route: assert property (p_order_a_route) else $error("first ordering register misrouted");

  // software should use the second register here; the first one drops these replays
  property p_retire_gate;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_replay_at_retire &&
       (i_split_access_select_reg_a[31:25] == 7'h04 || i_split_access_select_reg_a[31:25] == 7'h05))
      |=> !o_event_hit[0] && !o_count_inc[8] && !o_count_inc[9];
  endproperty
  a_retire_gate: assert property (p_retire_gate) else $error("at-retire replay via first register");

  property p_split_any_store;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_counter_enable[9] && i_counter_config_control_reg[9][15:13] == 3'h2 &&
       i_split_access_select_reg_a[31:25] == 7'h08 && i_split_access_select_reg_a[10] &&
       i_split_store_done) |=> o_count_inc[9] && o_event_hit[0];
  endproperty
  a_split_any_store: assert property (p_split_any_store) else $error("split completion missed");

  c_split_load: cover property (@(posedge i_clk) disable iff (!i_rstn) o_count_inc[8]);
  c_load_replay: cover property (@(posedge i_clk) disable iff (!i_rstn) o_count_inc[10]);
  c_order_replay: cover property (@(posedge i_clk) disable iff (!i_rstn) o_count_inc[0] ##1 o_count_inc[2]);
  c_store_replay: cover property (@(posedge i_clk) disable iff (!i_rstn) o_count_inc[9] && o_event_hit[0]);
  c_retire_b: cover property (@(posedge i_clk) disable iff (!i_rstn) i_replay_at_retire ##1 o_count_inc[10]);
endmodule : replay_split_event_select

// file: include/event_selection_control_reg_match_if.sv
`timescale 1ns/100ps
interface sel_match_if;
  logic [31:0] sel;
  logic        split_load_cause_bit;
  logic        split_load_cause_bit_ucwc;
  logic        split_store_cause_bit;
  logic [15:0] ld_cause;
  logic [15:0] st_cause;
  logic [15:0] order_cause;
  logic        at_retire;
  logic        hit;

  modport decoder (
    input  sel, split_load_cause_bit, split_load_cause_bit_ucwc, split_store_cause_bit, ld_cause, st_cause, order_cause, at_retire,
    output hit
  );
  modport owner (
    output sel, split_load_cause_bit, split_load_cause_bit_ucwc, split_store_cause_bit, ld_cause, st_cause, order_cause, at_retire,
    input  hit
  );
endinterface : sel_match_if

// file: include/replay_split_map.svh
`ifndef REPLAY_SPLIT_MAP_SVH
`define REPLAY_SPLIT_MAP_SVH

// event-selection register fields
`define RS_CODE_MSB 31
`define RS_CODE_LSB 25
`define RS_MASK_MSB 24
`define RS_MASK_LSB 9
`define RS_MASK_W 16

// event codes
`define RS_CODE_SPLIT_DONE 7'h08
`define RS_CODE_LOAD_REPLAY 7'h04
`define RS_CODE_STORE_REPLAY 7'h05

// event mask bit positions
`define RS_LOAD_SPLIT_COMPLETED_BIT 0
`define RS_STORE_SPLIT_COMPLETED_BIT 1
`define RS_SPLIT_LOAD_CAUSE_BIT 1
`define RS_SPLIT_STORE_CAUSE_BIT 1

// counter configuration selector field and values
`define RS_SEL_MSB 15
`define RS_SEL_LSB 13
`define RS_SEL_SPLIT 3'h2
`define RS_SEL_ORDER 3'h2

// counters served by each selection register
`define RS_ORDER_A_CTR0 0
`define RS_ORDER_A_CTR1 1
`define RS_ORDER_B_CTR0 2
`define RS_ORDER_B_CTR1 3
`define RS_SPLIT_A_CTR0 8
`define RS_SPLIT_A_CTR1 9
`define RS_SPLIT_B_CTR0 10
`define RS_SPLIT_B_CTR1 11
`define RS_NUM_COUNTERS 12

`endif

// file: include/replay_split_pkg.sv
package replay_split_pkg;

  typedef enum logic [3:0] {
    CLS_NONE        = 4'b0001,
    CLS_SPLIT_DONE  = 4'b0010,
    CLS_LOAD_REPLAY = 4'b0100,
    CLS_STORE_REPLAY = 4'b1000
  } event_class_e;

  // selection register index
  typedef logic [1:0] sel_idx_t;

  typedef struct packed {
    logic [11:0] inc;
    logic [3:0]  hit;
  } sel_state_s;

  function automatic event_class_e decode_class(input logic [6:0] code);
    event_class_e c;
    c = CLS_NONE;
    if (code == 7'h08) c = CLS_SPLIT_DONE;
    else if (code == 7'h04) c = CLS_LOAD_REPLAY;
    else if (code == 7'h05) c = CLS_STORE_REPLAY;
    return c;
  endfunction : decode_class

endpackage : replay_split_pkg

// file: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
  localparam int         NC  = 12;
  localparam logic [6:0] ORD = 7'h03;

  logic                i_clk        = 1'b0;
  logic                i_rstn       = 1'b0;
  logic [3:0][31:0]    sel_r        = '0;
  logic [NC-1:0][31:0] cfg          = '0;
  logic [NC-1:0]       en           = '0;
  logic                ld           = 1'b0;
  logic                ucwc         = 1'b0;
  logic                st           = 1'b0;
  logic                retire       = 1'b0;
  logic [15:0]         ldc          = '0;
  logic [15:0]         stc          = '0;
  logic [15:0]         mobc         = '0;
  logic [NC-1:0]       o_count_inc;
  logic [3:0]          o_event_hit;
  logic [31:0]         lfsr_state   = 32'h0000004A;
  logic [15:0]         exp_q        = '0;
  int                  bad_count    = 0;
  int                  total_checks = 0;

  always #50 i_clk = ~i_clk;

  replay_split_event_select #(.NUM_COUNTERS(NC), .ORDER_EVENT_CODE(ORD)) dut (
    .i_clk                               (i_clk),
    .i_rstn                              (i_rstn),
    .i_split_access_select_reg_a         (sel_r[0]),
    .i_split_access_select_reg_b         (sel_r[1]),
    .i_ordering_buffer_select_reg_a      (sel_r[2]),
    .i_ordering_buffer_select_reg_b      (sel_r[3]),
    .i_counter_config_control_reg        (cfg),
    .i_counter_enable                    (en),
    .i_split_load_done                   (ld),
    .i_split_load_ucwc                   (ucwc),
    .i_split_store_done                  (st),
    .i_load_replay_cause                 (ldc),
    .i_store_replay_cause                (stc),
    .i_ordering_buffer_load_replay_cause (mobc),
    .i_replay_at_retire                  (retire),
    .o_count_inc                         (o_count_inc),
    .o_event_hit                         (o_event_hit)
  );

  // whole word shifted per draw so successive draws are not just shifted copies
  function automatic logic [31:0] rnd();
    for (int n = 0; n < 32; n++) begin
      lfsr_state = {lfsr_state[30:0],
                    lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
    end
    return lfsr_state;
  endfunction : rnd

  function automatic logic split_hit(input logic [31:0] r, input logic is_b);
    logic [15:0] m;
    m = r[24:9];
    case (r[31:25])
      7'h08:   return (m[0] & ld & ~ucwc) | (m[1] & st);
      7'h04:   return (|(ldc & m)) & (is_b | ~retire);
      7'h05:   return (|(stc & m)) & (is_b | ~retire);
      default: return 1'b0;
    endcase
  endfunction : split_hit

  function automatic logic order_hit(input logic [31:0] r);
    return (r[31:25] == ORD) & (|(mobc & r[24:9]));
  endfunction : order_hit

  function automatic logic [15:0] model();
    logic [3:0]    h;
    logic [NC-1:0] c;
    h = {order_hit(sel_r[3]), order_hit(sel_r[2]), split_hit(sel_r[1], 1'b1), split_hit(sel_r[0], 1'b0)};
    for (int k = 0; k < NC; k++) begin
      c[k] = en[k] & (cfg[k][15:13] == 3'h2)
             & ((k < 2) ? h[2] : (k < 4) ? h[3] : (k < 8) ? 1'b0 : (k < 10) ? h[0] : h[1]);
    end
    return {c, h};
  endfunction : model

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // corners: counted split load, excluded uncacheable load, at-retire gating, selector off by one
  task automatic drive_corner(input int i);
    logic [6:0] cc[4];
    cc = '{7'h08, 7'h08, 7'h04, 7'h05};
    en     <= '1;
    ld     <= (i < 2);
    ucwc   <= (i == 1);
    st     <= 1'b0;
    retire <= (i == 2);
    ldc    <= 16'h0002;
    stc    <= 16'h0002;
    mobc   <= (i == 1) ? 16'h0002 : 16'h0001;
    for (int k = 0; k < NC; k++) cfg[k] <= {16'h0000, (i == 3 && k == 8) ? 3'h3 : 3'h2, 13'h0000};
    // load-only mask on corner 1 so the excluded uncacheable load is seen alone
    sel_r[0] <= {cc[i], (i == 1) ? 16'h0001 : 16'h0003, 9'h000};
    sel_r[1] <= {cc[i], 16'h0003, 9'h000};
    sel_r[2] <= {ORD, 16'h0002, 9'h000};
    sel_r[3] <= {ORD, 16'h0038, 9'h000};
  endtask : drive_corner

  task automatic drive_random();
    logic [6:0]  cc[5];
    logic [31:0] r;
    cc = '{7'h08, 7'h04, 7'h05, ORD, 7'h7F};
    for (int j = 0; j < 4; j++) begin
      r = rnd();
      sel_r[j] <= {cc[r[31:29] % 5], r[24:9] & r[15:0], r[8:0]};
    end
    for (int k = 0; k < NC; k++) begin
      r = rnd();
      cfg[k] <= {r[31:16], r[0] ? 3'h2 : r[3:1], r[12:0]};
      en[k]  <= r[5] | r[6];
    end
    r = rnd();
    ld     <= r[0];
    ucwc   <= r[1] & r[2];
    st     <= r[3];
    retire <= r[4];
    ldc    <= r[31:16] & r[15:0];
    r = rnd();
    stc    <= r[31:16] & r[15:0];
    mobc   <= r[31:16] & r[23:8];
  endtask : drive_random

  initial begin
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (int i = 0; i < 2000; i++) begin
      @(posedge i_clk);
      if (i < 4) drive_corner(i);
      else drive_random();
    end
    repeat (2) @(posedge i_clk);
    stop_test();
  end

  // outputs answer one edge after sampling, so compare against last cycle's model
  always @(negedge i_clk) begin
    if (i_rstn) begin
      check({4'h0, o_count_inc}, {4'h0, exp_q[15:4]});
      check({12'h000, o_event_hit}, {12'h000, exp_q[3:0]});
      exp_q = model();
    end
  end

  initial begin
    #400000;
    bad_count++;
    stop_test();
  end
endmodule : testbench
